// ### uart_far_side_model.sv
// far-side model: transmitter holding stage and receive dma reader
// assumes one clock shared with the block, synchronous active-low reset
`timescale 1ns/100ps
module uart_far_side_model #(
  parameter int REFILL_CYCLES = 30
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tx_write,
  input wire logic dma_go,
  output logic tx_empty,
  output logic dma_rx_read
);
  // ----------------------------------------------------------------
  // transmit holding stage
  // ----------------------------------------------------------------
  int busy_q;
  assign tx_empty = (busy_q == 0);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      busy_q <= 0;
    end else if (tx_write) begin
      busy_q <= REFILL_CYCLES;
    end else if (busy_q != 0) begin
      busy_q <= busy_q - 1;
    end
  end
  // ----------------------------------------------------------------
  // dma reader
  // ----------------------------------------------------------------
  // dma fifo read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dma_rx_read <= 1'b0;
    end else begin
      dma_rx_read <= dma_go;
    end
  end
endmodule

// ### uart_interrupt_identification.sv
// uart interrupt identification with avalon-mm register slave
// assumes receiver and transmitter datapaths drive the event inputs
`timescale 1ns/100ps
module uart_interrupt_identification
  import uart_irq_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic [5:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic [7:0] RX_DATA,
  input wire logic RX_PUSH,
  input wire logic [4:0] RX_FIFO_LEVEL,
  input wire logic DMA_RX_READ,
  input wire logic RX_OVERRUN,
  input wire logic RX_PARITY_ERR,
  input wire logic RX_FRAMING_ERR,
  input wire logic RX_BREAK,
  input wire logic RX_ERR_DATA_PENDING,
  input wire logic CHAR_TICK,
  input wire logic RX_RESET_LOAD0,
  input wire logic TX_EMPTY,
  output logic TX_WRITE,
  output logic [7:0] TX_DATA,
  output logic RX_READ,
  output logic RX_FIFO_CLEAR,
  output logic TX_FIFO_CLEAR,
  output logic FIFO_MODE,
  output logic DMA_MODE,
  output logic UART_INT,
  output logic IRQ
);

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  logic waitreq_q;
  logic [31:0] rdata_q;
  logic [31:0] rd_mux;

  wire logic req = AVS_READ | AVS_WRITE;
  wire logic take = req & waitreq_q;
  wire logic commit = req & ~waitreq_q;
  wire logic wr_commit = commit & AVS_WRITE;
  wire logic rd_commit = commit & AVS_READ;
  wire logic [5:0] word_addr = {AVS_ADDRESS[5:2], 2'b00};

  wire logic sel_rxtx = word_addr == OFS_RXTX;
  wire logic sel_ier = word_addr == OFS_IER;
  wire logic sel_iir = word_addr == OFS_IIR_FCR;
  wire logic sel_lsr = word_addr == OFS_LSR;
  wire logic sel_stat = word_addr == OFS_EVT_STAT;
  wire logic sel_mask = word_addr == OFS_EVT_MASK;

  wire logic thr_write = wr_commit & sel_rxtx;
  wire logic rbr_read = rd_commit & sel_rxtx;
  wire logic lsr_read = rd_commit & sel_lsr;
  wire logic ier_write = wr_commit & sel_ier;
  wire logic fcr_write = wr_commit & sel_iir;
  wire logic stat_write = wr_commit & sel_stat;
  wire logic mask_write = wr_commit & sel_mask;

  // one wait cycle, then the access completes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      waitreq_q <= 1'b1;
      rdata_q <= 32'h00000000;
    end else begin
      waitreq_q <= ~take;
      rdata_q <= (take & AVS_READ) ? rd_mux : rdata_q;
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [3:0] ier_q;
  logic fifo_mode_q;
  logic dma_mode_q;
  logic [1:0] trig_q;
  logic [3:0] evt_mask_q;
  logic tx_write_q;
  logic [7:0] tx_data_q;
  logic rx_read_q;
  logic rx_clr_q;
  logic tx_clr_q;

  wire logic fcr_en = AVS_WRITEDATA[FCR_FIFO_EN_BIT];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ier_q <= IER_RESET;
      fifo_mode_q <= 1'b0;
      dma_mode_q <= 1'b0;
      trig_q <= TRIG_RESET;
      evt_mask_q <= EVT_MASK_RESET;
    end else begin
      if (ier_write) begin
        ier_q <= AVS_WRITEDATA[3:0];
      end
      if (fcr_write) begin
        fifo_mode_q <= fcr_en;
        dma_mode_q <= fcr_en ? AVS_WRITEDATA[FCR_DMA_BIT] : dma_mode_q;
        trig_q <= fcr_en ? AVS_WRITEDATA[FCR_TRIG_LSB +: 2] : trig_q;
      end
      if (mask_write) begin
        evt_mask_q <= AVS_WRITEDATA[3:0];
      end
    end
  end

  // strobes to the datapaths
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      tx_write_q <= 1'b0;
      tx_data_q <= 8'h00;
      rx_read_q <= 1'b0;
      rx_clr_q <= 1'b0;
      tx_clr_q <= 1'b0;
    end else begin
      tx_write_q <= thr_write;
      tx_data_q <= thr_write ? AVS_WRITEDATA[7:0] : tx_data_q;
      rx_read_q <= rbr_read;
      rx_clr_q <= fcr_write & (~fcr_en | AVS_WRITEDATA[FCR_RX_CLR_BIT]);
      tx_clr_q <= fcr_write & (~fcr_en | AVS_WRITEDATA[FCR_TX_CLR_BIT]);
    end
  end

  // ----------------------------------------------------------------
  // line status source
  // ----------------------------------------------------------------
  logic ovr_q;
  logic pe_q;
  logic fe_q;
  logic bi_q;
  logic err_irq_q;

  wire logic new_err = RX_PARITY_ERR | RX_FRAMING_ERR | RX_BREAK;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ovr_q <= 1'b0;
      pe_q <= 1'b0;
      fe_q <= 1'b0;
      bi_q <= 1'b0;
      err_irq_q <= 1'b0;
    end else begin
      ovr_q <= RX_OVERRUN | (ovr_q & ~lsr_read);
      pe_q <= RX_PARITY_ERR | (pe_q & ~lsr_read);
      fe_q <= RX_FRAMING_ERR | (fe_q & ~lsr_read);
      bi_q <= RX_BREAK | (bi_q & ~lsr_read);
      err_irq_q <= new_err | (err_irq_q & RX_ERR_DATA_PENDING);
    end
  end

  wire logic src_line = ovr_q | err_irq_q;

  // ----------------------------------------------------------------
  // receive data and timeout sources
  // ----------------------------------------------------------------
  logic rdy_q;
  logic renew_q;
  logic src_timeout;
  logic to_expire;

  wire logic fifo_pop = rbr_read | DMA_RX_READ;
  wire logic fifo_access = RX_PUSH | fifo_pop;
  wire logic above_trig = RX_FIFO_LEVEL >= trigger_level(trig_q);

  uart_rx_timeout u_timeout (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .fifo_mode(fifo_mode_q),
    .nonempty(RX_FIFO_LEVEL != 5'h00),
    .char_tick(CHAR_TICK),
    .push(RX_PUSH),
    .pop(fifo_pop),
    .rx_reset_load0(RX_RESET_LOAD0),
    .timeout(src_timeout),
    .expire(to_expire)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdy_q <= 1'b0;
      renew_q <= 1'b0;
    end else begin
      // set on arrival, cleared by buffer read
      rdy_q <= RX_PUSH | (rdy_q & ~rbr_read & ~rx_clr_q);
      renew_q <= (to_expire & above_trig) | (renew_q & ~fifo_access & fifo_mode_q);
    end
  end

  wire logic src_data = fifo_mode_q ? (above_trig | renew_q) : rdy_q;

  // ----------------------------------------------------------------
  // transmit empty source
  // ----------------------------------------------------------------
  logic thre_arm_q;
  logic tx_empty_prev_q;

  wire logic tx_drained = TX_EMPTY & ~tx_empty_prev_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      thre_arm_q <= 1'b1;
      tx_empty_prev_q <= 1'b1;
    end else begin
      tx_empty_prev_q <= TX_EMPTY;
      thre_arm_q <= tx_drained | (thre_arm_q & ~thr_write);
    end
  end

  wire logic src_tx = thre_arm_q & TX_EMPTY;

  // ----------------------------------------------------------------
  // prioritisation and identification
  // ----------------------------------------------------------------
  int_code_t code;
  logic any;
  int_code_t type_q;
  logic pend_n_q;
  logic uart_int_q;

  uart_irq_priority u_prio (
    .src_line(src_line),
    .src_data(src_data),
    .src_timeout(src_timeout),
    .src_tx(src_tx),
    .interrupt_enable_register(ier_q),
    .code(code),
    .any(any)
  );

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      type_q <= INT_NONE;
      pend_n_q <= 1'b1;
      uart_int_q <= 1'b0;
    end else begin
      type_q <= code;
      pend_n_q <= ~any;
      uart_int_q <= any;
    end
  end

  wire logic [1:0] fifo_field = fifo_mode_q ? FIFO_FIELD_ON : FIFO_FIELD_OFF;
  wire logic [31:0] iir_word = {24'h000000, fifo_field, 2'b00, type_q, pend_n_q};

  // ----------------------------------------------------------------
  // event status and mask
  // ----------------------------------------------------------------
  logic [3:0] evt_stat_q;
  logic [3:0] en_src_prev_q;
  logic irq_q;

  wire logic [3:0] en_src = {src_tx & ier_q[IER_TX_EMPTY_BIT],
                             src_timeout & ier_q[IER_RX_DATA_BIT],
                             src_data & ier_q[IER_RX_DATA_BIT],
                             src_line & ier_q[IER_LINE_BIT]};
  wire logic [3:0] evt_rise = en_src & ~en_src_prev_q;
  wire logic [3:0] evt_clr = stat_write ? AVS_WRITEDATA[3:0] : 4'h0;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      evt_stat_q <= 4'h0;
      en_src_prev_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      en_src_prev_q <= en_src;
      evt_stat_q <= evt_rise | (evt_stat_q & ~evt_clr);
      irq_q <= |(evt_stat_q & evt_mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read data selection
  // ----------------------------------------------------------------
  wire logic [7:0] lsr_word = {2'b00, src_tx, bi_q, fe_q, pe_q, ovr_q, src_data};

  assign rd_mux = sel_rxtx ? {24'h000000, RX_DATA} :
                  sel_ier ? {28'h0000000, ier_q} :
                  sel_iir ? iir_word :
                  sel_lsr ? {24'h000000, lsr_word} :
                  sel_stat ? {28'h0000000, evt_stat_q} :
                  sel_mask ? {28'h0000000, evt_mask_q} : 32'h00000000;

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign AVS_READDATA = rdata_q;
  assign AVS_WAITREQUEST = waitreq_q;
  assign TX_WRITE = tx_write_q;
  assign TX_DATA = tx_data_q;
  assign RX_READ = rx_read_q;
  assign RX_FIFO_CLEAR = rx_clr_q;
  assign TX_FIFO_CLEAR = tx_clr_q;
  assign FIFO_MODE = fifo_mode_q;
  assign DMA_MODE = dma_mode_q;
  assign UART_INT = uart_int_q;
  assign IRQ = irq_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_taken;
    req && waitreq_q;
  endsequence
  sequence s_done;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence

  AST_BUS_ONE_WAIT: assert property (s_taken |=> s_done)
    else $error("access did not complete after one wait cycle");
  AST_NO_ENABLE: assert property (ier_q == 4'h0 |=> pend_n_q)
    else $error("pending flag low with no source enabled");
  AST_PEND_LOW: assert property (any |=> !pend_n_q && UART_INT)
    else $error("enabled source did not drive pending flag low");
  AST_PEND_IDLE: assert property (!any |=> pend_n_q && type_q == INT_NONE)
    else $error("idle identification is not 0001");
  AST_LINE_FIRST: assert property (src_line && ier_q[IER_LINE_BIT] |=> type_q == INT_RX_LINE)
    else $error("line status not reported first");
  AST_OVR_CLEAR: assert property (ovr_q && lsr_read && !RX_OVERRUN |=> !ovr_q)
    else $error("overrun survived a status read");
  AST_RBR_CLEAR: assert property (!fifo_mode_q && rbr_read && !RX_PUSH |=> !src_data)
    else $error("data ready survived a buffer read");
  AST_THR_CLEAR: assert property (thr_write && !tx_drained |=> !src_tx)
    else $error("transmit empty survived a holding write");
  AST_FIFO_FIELD: assert property (rd_commit && sel_iir && fifo_mode_q |->
    AVS_READDATA[7:6] == FIFO_FIELD_ON)
    else $error("fifo field wrong in fifo mode");

endmodule

// ### uart_interrupt_identification_bench.sv
// testbench for the uart interrupt identification block
// assumes the far-side model drives transmit empty and dma reads
`timescale 1ns/100ps
module uart_interrupt_identification_bench;
  import uart_irq_pkg::*;
  // ----------------------------------------------------------------
  // stimulus and wiring
  // ----------------------------------------------------------------
  logic CORE_CLK = 1'b0;
  logic RST_N = 1'b0;
  logic [5:0] AVS_ADDRESS = 6'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic RX_PUSH = 1'b0;
  logic [4:0] RX_FIFO_LEVEL = 5'h01;
  logic RX_OVERRUN = 1'b0;
  logic RX_PARITY_ERR = 1'b0;
  logic RX_FRAMING_ERR = 1'b0;
  logic RX_BREAK = 1'b0;
  logic RX_ERR_DATA_PENDING = 1'b0;
  logic CHAR_TICK = 1'b0;
  logic RX_RESET_LOAD0 = 1'b0;
  logic dma_go = 1'b0;
  logic TX_EMPTY, DMA_RX_READ, TX_WRITE, RX_READ, FIFO_MODE, DMA_MODE, UART_INT, IRQ;
  logic RX_FIFO_CLEAR, TX_FIFO_CLEAR;
  logic [7:0] TX_DATA;
  logic [31:0] rd;
  int err_count = 0;
  int n_compared = 0;
  always #25 CORE_CLK = ~CORE_CLK;

  uart_interrupt_identification i_dut (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .RX_DATA(8'hA5), .RX_PUSH(RX_PUSH),
    .RX_FIFO_LEVEL(RX_FIFO_LEVEL), .DMA_RX_READ(DMA_RX_READ), .RX_OVERRUN(RX_OVERRUN),
    .RX_PARITY_ERR(RX_PARITY_ERR), .RX_FRAMING_ERR(RX_FRAMING_ERR), .RX_BREAK(RX_BREAK),
    .RX_ERR_DATA_PENDING(RX_ERR_DATA_PENDING), .CHAR_TICK(CHAR_TICK),
    .RX_RESET_LOAD0(RX_RESET_LOAD0), .TX_EMPTY(TX_EMPTY), .TX_WRITE(TX_WRITE),
    .TX_DATA(TX_DATA), .RX_READ(RX_READ), .RX_FIFO_CLEAR(RX_FIFO_CLEAR),
    .TX_FIFO_CLEAR(TX_FIFO_CLEAR),
    .FIFO_MODE(FIFO_MODE), .DMA_MODE(DMA_MODE), .UART_INT(UART_INT), .IRQ(IRQ));

  uart_far_side_model i_far (
    .clk(CORE_CLK), .rst_n(RST_N), .tx_write(TX_WRITE), .dma_go(dma_go),
    .tx_empty(TX_EMPTY), .dma_rx_read(DMA_RX_READ));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] wd);
    int n;
    @(posedge CORE_CLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= wd;
    AVS_READ <= ~we;
    AVS_WRITE <= we;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (n >= 20) begin
      err_count++;
      report_and_stop();
    end
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] exp, input logic [31:0] m);
    bus(1'b0, a, 32'h0);
    chk(rd & m, exp);
  endtask

  task automatic settle;
    repeat (4) @(posedge CORE_CLK);
  endtask

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge CORE_CLK);
      CHAR_TICK <= 1'b1;
      @(posedge CORE_CLK);
      CHAR_TICK <= 1'b0;
      repeat (2) @(posedge CORE_CLK);
    end
    settle();
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    chk({31'h0, UART_INT}, 32'h0);
    @(posedge CORE_CLK);
    RX_OVERRUN <= 1'b1;
    @(posedge CORE_CLK);
    RX_OVERRUN <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    chk({31'h0, UART_INT}, 32'h0);
    bus(1'b1, OFS_IER, 32'h0000_0004);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0006, 32'hFFFF_FFFF);
    chk({31'h0, UART_INT}, 32'h1);
    rdc(OFS_LSR, 32'h0000_0002, 32'h0000_001F);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    chk({31'h0, UART_INT}, 32'h0);
    // all sources enabled, error and character together
    bus(1'b1, OFS_IER, 32'h0000_0007);
    @(posedge CORE_CLK);
    RX_PUSH <= 1'b1;
    RX_PARITY_ERR <= 1'b1;
    RX_ERR_DATA_PENDING <= 1'b1;
    @(posedge CORE_CLK);
    RX_PUSH <= 1'b0;
    RX_PARITY_ERR <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0006, 32'hFFFF_FFFF);
    rdc(OFS_LSR, 32'h0000_0005, 32'h0000_001F);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0006, 32'hFFFF_FFFF);
    RX_ERR_DATA_PENDING <= 1'b0;
    rdc(OFS_RXTX, 32'h0000_00A5, 32'h0000_00FF);
    @(posedge CORE_CLK);
    chk({31'h0, RX_READ}, 32'h1);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0002, 32'hFFFF_FFFF);
    bus(1'b1, OFS_RXTX, 32'h0000_005A);
    @(posedge CORE_CLK);
    chk({23'h0, TX_WRITE, TX_DATA}, 32'h0000_015A);
    settle();
    chk({24'h0, TX_DATA}, 32'h0000_005A);
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    repeat (40) @(posedge CORE_CLK);
    rdc(OFS_IIR_FCR, 32'h0000_0002, 32'hFFFF_FFFF);
    bus(1'b1, OFS_IER, 32'h0000_0000);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    // fifo mode, trigger of four characters, timeout reported as event
    bus(1'b1, OFS_IIR_FCR, 32'h0000_0049);
    bus(1'b1, OFS_IER, 32'h0000_0001);
    bus(1'b1, OFS_EVT_MASK, 32'h0000_0004);
    chk({30'h0, FIFO_MODE, DMA_MODE}, 32'h0000_0003);
    @(posedge CORE_CLK);
    RX_FIFO_LEVEL <= 5'h02;
    RX_PUSH <= 1'b1;
    @(posedge CORE_CLK);
    RX_PUSH <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_00C1, 32'hFFFF_FFFF);
    ticks(5);
    rdc(OFS_IIR_FCR, 32'h0000_00CC, 32'hFFFF_FFFF);
    chk({31'h0, IRQ}, 32'h1);
    rdc(OFS_EVT_STAT, 32'h0000_0004, 32'h0000_0004);
    bus(1'b1, OFS_EVT_STAT, 32'h0000_0004);
    settle();
    chk({31'h0, IRQ}, 32'h0);
    dma_go <= 1'b1;
    RX_FIFO_LEVEL <= 5'h01;
    @(posedge CORE_CLK);
    dma_go <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_00C1, 32'hFFFF_FFFF);
    ticks(5);
    rdc(OFS_IIR_FCR, 32'h0000_00CC, 32'hFFFF_FFFF);
    RX_RESET_LOAD0 <= 1'b1;
    @(posedge CORE_CLK);
    RX_RESET_LOAD0 <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_00C1, 32'hFFFF_FFFF);
    ticks(5);
    RX_FIFO_LEVEL <= 5'h04;
    RX_PUSH <= 1'b1;
    @(posedge CORE_CLK);
    RX_PUSH <= 1'b0;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_00C4, 32'hFFFF_FFFF);
    RX_FIFO_LEVEL <= 5'h03;
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_00C1, 32'hFFFF_FFFF);
    // back to non-fifo mode, then an unmapped place
    bus(1'b1, OFS_IIR_FCR, 32'h0000_0000);
    @(posedge CORE_CLK);
    chk({29'h0, FIFO_MODE, RX_FIFO_CLEAR, TX_FIFO_CLEAR}, 32'h0000_0003);
    settle();
    rdc(OFS_IIR_FCR, 32'h0000_0001, 32'hFFFF_FFFF);
    rdc(6'h30, 32'h0000_0000, 32'hFFFF_FFFF);
    report_and_stop();
  end
endmodule

// ### uart_irq_pkg.sv
// uart interrupt identification: shared constants and types
// assumes byte addresses on a 32-bit avalon-mm slave, one word per register
// How it works
// - three-bit type code: 1,2,3,6 used
// - line status highest, transmit empty lowest
// - enabled raised source forces pending flag low
// - flag stays low until all cleared
// - no enabled source, flag never low
// - idle reads flag 1, low bits 0001
// - overrun, parity, framing, break raise line status
// - overrun clears on status read, others later
// - non-fifo data ready clears on buffer read
// - fifo data ready follows trigger, renews
// - fifo timeout after four idle character times
// - timeout clears on read, arrival, reset
// - transmit empty raised on holding/fifo empty
// - transmit empty clears on holding write
// - cpu or dma read clears fifo sources
// - only enabled sources reach the processor
// - fifo status bits 7:6 read 0 or 3
package uart_irq_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [5:0] OFS_RXTX = 6'h00;
  localparam logic [5:0] OFS_IER = 6'h04;
  localparam logic [5:0] OFS_IIR_FCR = 6'h08;
  localparam logic [5:0] OFS_LSR = 6'h14;
  localparam logic [5:0] OFS_EVT_STAT = 6'h20;
  localparam logic [5:0] OFS_EVT_MASK = 6'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int IER_RX_DATA_BIT = 0;
  localparam int IER_TX_EMPTY_BIT = 1;
  localparam int IER_LINE_BIT = 2;
  localparam int FCR_FIFO_EN_BIT = 0;
  localparam int FCR_RX_CLR_BIT = 1;
  localparam int FCR_TX_CLR_BIT = 2;
  localparam int FCR_DMA_BIT = 3;
  localparam int FCR_TRIG_LSB = 6;
  localparam int LSR_DR_BIT = 0;
  localparam int LSR_OE_BIT = 1;
  localparam int LSR_PE_BIT = 2;
  localparam int LSR_FE_BIT = 3;
  localparam int LSR_BI_BIT = 4;
  localparam int LSR_THRE_BIT = 5;
  localparam int EVT_LINE_BIT = 0;
  localparam int EVT_RX_DATA_BIT = 1;
  localparam int EVT_TIMEOUT_BIT = 2;
  localparam int EVT_TX_EMPTY_BIT = 3;

  // ----------------------------------------------------------------
  // values and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] FIFO_FIELD_ON = 2'h3;
  localparam logic [1:0] FIFO_FIELD_OFF = 2'h0;
  localparam logic [3:0] IER_RESET = 4'h0;
  localparam logic [3:0] EVT_MASK_RESET = 4'h0;
  localparam logic [1:0] TRIG_RESET = 2'h0;
  localparam logic [2:0] TIMEOUT_CHARS = 3'h4;

  typedef enum logic [2:0] {
    INT_NONE = 3'h0,
    INT_TX_EMPTY = 3'h1,
    INT_RX_DATA = 3'h2,
    INT_RX_LINE = 3'h3,
    INT_RX_TIMEOUT = 3'h6
  } int_code_t;

  // receive fifo trigger level in characters
  function automatic logic [4:0] trigger_level(input logic [1:0] sel);
    logic [4:0] lvl;
    lvl = 5'h01;
    case (sel)
      2'h0: lvl = 5'h01;
      2'h1: lvl = 5'h04;
      2'h2: lvl = 5'h08;
      2'h3: lvl = 5'h0E;
    endcase
    return lvl;
  endfunction

endpackage

// ### uart_irq_priority.sv
// priority encoder for the four interrupt sources
// assumes sources and enables are synchronous levels
`timescale 1ns/100ps
module uart_irq_priority
  import uart_irq_pkg::*;
(
  input wire logic src_line,
  input wire logic src_data,
  input wire logic src_timeout,
  input wire logic src_tx,
  input wire logic [3:0] interrupt_enable_register,
  output int_code_t code,
  output logic any
);

  wire logic en_line = src_line & interrupt_enable_register[IER_LINE_BIT];
  wire logic en_data = src_data & interrupt_enable_register[IER_RX_DATA_BIT];
  wire logic en_to = src_timeout & interrupt_enable_register[IER_RX_DATA_BIT];
  wire logic en_tx = src_tx & interrupt_enable_register[IER_TX_EMPTY_BIT];

  assign code = en_line ? INT_RX_LINE :
                en_data ? INT_RX_DATA :
                en_to ? INT_RX_TIMEOUT :
                en_tx ? INT_TX_EMPTY : INT_NONE;
  assign any = en_line | en_data | en_to | en_tx;

endmodule

// ### uart_rx_timeout.sv
// receive character timeout counter
// assumes char_tick pulses once per character time
`timescale 1ns/100ps
module uart_rx_timeout
  import uart_irq_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic fifo_mode,
  input wire logic nonempty,
  input wire logic char_tick,
  input wire logic push,
  input wire logic pop,
  input wire logic rx_reset_load0,
  output logic timeout,
  output logic expire
);

  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic to_q;
  logic to_d;
  logic exp_q;

  // ----------------------------------------------------------------
  // idle counting
  // ----------------------------------------------------------------
  wire logic clr = push | pop | rx_reset_load0 | ~fifo_mode | ~nonempty;
  wire logic reach = char_tick & (cnt_q == TIMEOUT_CHARS - 3'h1);

  assign cnt_d = clr ? 3'h0 : (char_tick && cnt_q != TIMEOUT_CHARS) ? cnt_q + 3'h1 : cnt_q;
  assign to_d = clr ? 1'b0 : (to_q | reach);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 3'h0;
      to_q <= 1'b0;
      exp_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      to_q <= to_d;
      exp_q <= ~clr & reach;
    end
  end

  assign timeout = to_q;
  assign expire = exp_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_TO_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    (push | pop | rx_reset_load0) |=> !to_q)
    else $error("timeout survived a clearing event");
  AST_TO_FIFO_ONLY: assert property (@(posedge clk) disable iff (!rst_n)
    !fifo_mode |=> !to_q)
    else $error("timeout raised outside fifo mode");

endmodule
